// *** core/isaw_watchpoints.sv ***
// instruction-address and store-address range watchpoint channels
//
// Operation
// - only fetches that execute can hit
// - watch flag zero suppresses instruction channels
// - instruction hit raised before it executes
// - instruction ranges 32-bit, upper half zero
// - instruction hit when start <= addr < end
// - effective address with translation, else physical
// - all range compares are unsigned
// - expanded compact code uses original address
// - vector 0x100, or 0x0 when blocked
// - instruction exception code loaded with 0x900
// - matching instruction address saved as pc
// - channel qualifiers gate every hit
// - store hit raised before the write
// - watch flag zero suppresses store channels
// - store ranges hold bits 31 to 5
// - store address compared at 32-byte blocks
// - store hit when start <= block <= end
// - candidate stores in the hole raise address error
// - native stores, allocate, invalidate are candidates
// - high-part store uses its own block
// - compact indirect stores are candidates
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "isaw_defs.svh"

module isaw_watchpoints #(
  parameter int NUM_IA = 2,
  parameter int NUM_OA = 2,
  parameter int NEFF   = 32
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  // register port
  input  wire logic [`ISAW_ADDR_W-1:0]    regAddr,
  input  wire logic [63:0]                regWdata,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic      [63:0]                regRdata,
  // processor state
  input  wire logic                       watchEnableFlag,
  input  wire logic                       blockBit,
  input  wire logic                       mmuEnable,
  input  wire logic [7:0]                 curAsid,
  input  wire logic                       curIsaMode,
  input  wire logic                       curPriv,
  input  wire logic [15:0]                ecountReached,
  input  wire logic [15:0]                chainArmed,
  // fetch side
  input  wire logic                       fetchValid,
  input  wire logic                       fetchWillExecute,
  input  wire logic                       fetchSeqCont,
  input  wire logic [63:0]                fetchEffAddr,
  input  wire logic [63:0]                fetchPhysAddr,
  // store side
  input  wire logic                       storeValid,
  input  wire isaw_pkg::isaw_store_kind_t storeKind,
  input  wire logic [63:0]                storeEffAddr,
  input  wire logic [63:0]                storePhysAddr,
  // hits and exception request
  output logic      [NUM_IA-1:0]          iaHit,
  output logic      [NUM_OA-1:0]          oaHit,
  output logic                            writeAddressError,
  output logic                            debugExcReq,
  output logic      [11:0]                debugVectorOffset,
  output logic      [11:0]                exceptionEventCode,
  output logic      [63:0]                savedProgramCounter,
  output logic      [63:0]                excOperandAddr
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (NUM_IA < 1 || NUM_IA > 8 || NUM_OA < 1 || NUM_OA > 8) begin : g_chan_check
    $error("isaw_watchpoints: channel counts must be 1 to 8");
  end
  if (NEFF < 32 || NEFF > 64) begin : g_neff_check
    $error("isaw_watchpoints: NEFF must be 32 to 64");
  end

  // ****************************************
  // assertion defaults
  // ****************************************
  default clocking assertClk @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ****************************************
  // helpers
  // ****************************************
  // register decode, shared by the write and read paths
  function automatic logic regHit(input logic [`ISAW_ADDR_W-1:0] a, input logic [3:0] base,
                                  input int ch, input logic [1:0] sub);
    regHit = a[11:8] == base && a[7:5] == 3'(ch) && a[4:3] == sub && a[2:0] == 3'h0;
  endfunction

  // qualifier gate, identical for both channel types
  function automatic logic qualOk(input logic [63:0] q, input logic [7:0] asid,
                                  input logic isa, input logic priv,
                                  input logic [15:0] ecnt, input logic [15:0] chain);
    logic [7:0] qAsid;
    qAsid  = q[`ISAW_Q_ASID_LSB +: 8];
    qualOk = q[`ISAW_Q_ENABLE]
           && (!q[`ISAW_Q_ASID_EN]    || asid == qAsid)
           && (!q[`ISAW_Q_DM_ASID_EN] || asid == qAsid)
           && (!q[`ISAW_Q_ISA_EN]     || isa == q[`ISAW_Q_ISA_VAL])
           && (!q[`ISAW_Q_PRIV_EN]    || priv == q[`ISAW_Q_PRIV_VAL])
           && (!q[`ISAW_Q_ECNT_EN]    || ecnt[q[`ISAW_Q_ECNT_LSB +: 4]])
           && (!q[`ISAW_Q_CHAIN_EN]   || chain[q[`ISAW_Q_CHAIN_LSB +: 4]]);
  endfunction

  // store classes that may hit a store channel
  function automatic logic storeCandidate(input isaw_pkg::isaw_store_kind_t k);
    storeCandidate = k == isaw_pkg::STORE_PLAIN || k == isaw_pkg::STORE_FLOAT
                  || k == isaw_pkg::STORE_SWAP || k == isaw_pkg::STORE_LOW_PART
                  || k == isaw_pkg::STORE_HIGH_PART || k == isaw_pkg::STORE_BLOCK_ALLOC
                  || k == isaw_pkg::STORE_BLOCK_INVAL || k == isaw_pkg::STORE_COMPACT_IND;
  endfunction

  // ****************************************
  // compared addresses and gating
  // ****************************************
  // pipeline hands both views; translation state picks one
  wire logic [63:0] fetchCmpAddr = mmuEnable ? fetchEffAddr : fetchPhysAddr;
  wire logic [63:0] storeCmpAddr = mmuEnable ? storeEffAddr : storePhysAddr;
  // expanded compact sequences present the compact address once, continuations stay quiet
  wire logic fetchQualifies = fetchValid && fetchWillExecute && !fetchSeqCont
                              && watchEnableFlag;
  // high-part stores run downward but still compare their own block
  wire logic [63:0] storeBlock = {storeCmpAddr[63:`ISAW_BLOCK_SHIFT],
                                  {`ISAW_BLOCK_SHIFT{1'b0}}};
  wire logic [63-NEFF+1:0] storeTop = storeEffAddr[63:NEFF-1];
  wire logic storeInHole = mmuEnable && !(&storeTop) && (|storeTop);
  wire logic storeIsCand = storeValid && storeCandidate(storeKind);
  wire logic storeQualifies = storeIsCand && !storeInHole && watchEnableFlag;

  // ****************************************
  // channel registers and comparators
  // ****************************************
  logic [31:0] iaStart [NUM_IA];
  logic [31:0] iaEnd   [NUM_IA];
  logic [63:0] iaQual  [NUM_IA];
  logic [26:0] oaStart [NUM_OA];
  logic [26:0] oaEnd   [NUM_OA];
  logic [63:0] oaQual  [NUM_OA];
  logic [63:0] iaRd    [NUM_IA];
  logic [63:0] oaRd    [NUM_OA];
  logic [NUM_IA-1:0] next_iaHit;
  logic [NUM_OA-1:0] next_oaHit;
  logic [NUM_IA-1:0] iaExcSel;
  logic [NUM_OA-1:0] oaExcSel;

  for (genvar i = 0; i < NUM_IA; i++) begin : g_ia
    wire logic wrS = regWrite && regHit(regAddr, `ISAW_IA_BASE, i, `ISAW_SUB_START);
    wire logic wrE = regWrite && regHit(regAddr, `ISAW_IA_BASE, i, `ISAW_SUB_END);
    wire logic wrQ = regWrite && regHit(regAddr, `ISAW_IA_BASE, i, `ISAW_SUB_QUAL);
    // unsigned 64-bit compare against zero-extended 32-bit limits
    wire logic inRange = fetchCmpAddr >= {32'h0000_0000, iaStart[i]}
                      && fetchCmpAddr <  {32'h0000_0000, iaEnd[i]};
    wire logic gateOk  = qualOk(iaQual[i], curAsid, curIsaMode, curPriv,
                                ecountReached, chainArmed);
    assign next_iaHit[i] = fetchQualifies && inRange && gateOk;
    assign iaExcSel[i]   = next_iaHit[i] && iaQual[i][`ISAW_Q_ACT_EXC];
    assign iaRd[i] = regHit(regAddr, `ISAW_IA_BASE, i, `ISAW_SUB_START) ? {32'h0000_0000, iaStart[i]} :
                     regHit(regAddr, `ISAW_IA_BASE, i, `ISAW_SUB_END)   ? {32'h0000_0000, iaEnd[i]}   :
                     regHit(regAddr, `ISAW_IA_BASE, i, `ISAW_SUB_QUAL)  ? iaQual[i] : 64'h0;

    a_ia_enable_gate: assert property (
      !iaQual[i][`ISAW_Q_ENABLE] |=> !iaHit[i])
      else $error("disabled channel hit");
    a_ia_space_id: assert property (
      iaQual[i][`ISAW_Q_ASID_EN] && curAsid != iaQual[i][`ISAW_Q_ASID_LSB +: 8] |=> !iaHit[i])
      else $error("space id mismatch hit");
    a_ia_priv_gate: assert property (
      iaQual[i][`ISAW_Q_PRIV_EN] && curPriv != iaQual[i][`ISAW_Q_PRIV_VAL] |=> !iaHit[i])
      else $error("privilege mismatch hit");

    // upper half is not stored, so it reads zero and ignores writes
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        iaStart[i] <= 32'h0000_0000;
        iaEnd[i]   <= 32'h0000_0000;
        iaQual[i]  <= `ISAW_QUAL_RESET;
      end else begin
        if (wrS) iaStart[i] <= regWdata[31:0];
        if (wrE) iaEnd[i]   <= regWdata[31:0];
        if (wrQ) iaQual[i]  <= regWdata & `ISAW_QUAL_MASK;
      end
    end
  end

  for (genvar j = 0; j < NUM_OA; j++) begin : g_oa
    wire logic wrS = regWrite && regHit(regAddr, `ISAW_OA_BASE, j, `ISAW_SUB_START);
    wire logic wrE = regWrite && regHit(regAddr, `ISAW_OA_BASE, j, `ISAW_SUB_END);
    wire logic wrQ = regWrite && regHit(regAddr, `ISAW_OA_BASE, j, `ISAW_SUB_QUAL);
    wire logic [63:0] lo = {32'h0000_0000, oaStart[j], 5'h00};
    wire logic [63:0] hi = {32'h0000_0000, oaEnd[j], 5'h00};
    // both limits inclusive, block-aligned on every side
    wire logic inRange = storeBlock >= lo && storeBlock <= hi;
    wire logic gateOk  = qualOk(oaQual[j], curAsid, curIsaMode, curPriv,
                                ecountReached, chainArmed);
    assign next_oaHit[j] = storeQualifies && inRange && gateOk;
    assign oaExcSel[j]   = next_oaHit[j] && oaQual[j][`ISAW_Q_ACT_EXC];
    assign oaRd[j] = regHit(regAddr, `ISAW_OA_BASE, j, `ISAW_SUB_START) ? lo :
                     regHit(regAddr, `ISAW_OA_BASE, j, `ISAW_SUB_END)   ? hi :
                     regHit(regAddr, `ISAW_OA_BASE, j, `ISAW_SUB_QUAL)  ? oaQual[j] : 64'h0;

    a_oa_enable_gate: assert property (
      !oaQual[j][`ISAW_Q_ENABLE] |=> !oaHit[j])
      else $error("disabled channel hit");

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        oaStart[j] <= 27'h000_0000;
        oaEnd[j]   <= 27'h000_0000;
        oaQual[j]  <= `ISAW_QUAL_RESET;
      end else begin
        if (wrS) oaStart[j] <= regWdata[31:5];
        if (wrE) oaEnd[j]   <= regWdata[31:5];
        if (wrQ) oaQual[j]  <= regWdata & `ISAW_QUAL_MASK;
      end
    end
  end

  // ****************************************
  // exception selection
  // ****************************************
  // the store is older in the pipe than the fetch, so it wins a same-cycle clash
  wire logic oaExc = |oaExcSel;
  wire logic iaExc = |iaExcSel;
  wire logic next_excReq = oaExc || iaExc;
  wire logic [11:0] next_vec  = blockBit ? `ISAW_VEC_PANIC : `ISAW_VEC_DEBUG;
  wire logic [11:0] next_code = oaExc ? `ISAW_EXP_OA : `ISAW_EXP_IA;

  // ****************************************
  // status word and read path
  // ****************************************
  logic [63:0] statusWord;
  logic [63:0] rdMux;

  always_comb begin
    rdMux = 64'h0;
    for (int k = 0; k < NUM_IA; k++) rdMux = rdMux | iaRd[k];
    for (int k = 0; k < NUM_OA; k++) rdMux = rdMux | oaRd[k];
    if (regAddr == {`ISAW_STAT_BASE, 8'h00}) rdMux = statusWord;
  end

  // ****************************************
  // output registers
  // ****************************************
  // hits leave one edge after presentation; the pipeline holds the
  // instruction short of execute or write-back for that cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      iaHit               <= '0;
      oaHit               <= '0;
      writeAddressError   <= 1'b0;
      debugExcReq         <= 1'b0;
      debugVectorOffset   <= `ISAW_VEC_DEBUG;
      exceptionEventCode  <= `ISAW_EXP_IA;
      savedProgramCounter <= 64'h0;
      excOperandAddr      <= 64'h0;
      statusWord          <= 64'h0;
      regRdata            <= 64'h0;
    end else begin
      iaHit             <= next_iaHit;
      oaHit             <= next_oaHit;
      writeAddressError <= storeIsCand && storeInHole;
      debugExcReq       <= next_excReq;
      regRdata          <= regRead ? rdMux : regRdata;
      if (next_excReq) begin
        debugVectorOffset  <= next_vec;
        exceptionEventCode <= next_code;
      end
      if (iaExc) savedProgramCounter <= fetchEffAddr;
      if (oaExc) excOperandAddr <= storeEffAddr;
      if ((|next_iaHit) || (|next_oaHit)) statusWord <= {48'h0, 8'(next_oaHit), 8'(next_iaHit)};
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_ia_watch_gate: assert property (@(posedge clk) disable iff (!reset_n)
    !watchEnableFlag |=> iaHit == '0) else $error("instruction hit with watch flag clear");
  a_oa_watch_gate: assert property (@(posedge clk) disable iff (!reset_n)
    !watchEnableFlag |=> oaHit == '0) else $error("store hit with watch flag clear");
  a_ia_spec_block: assert property (@(posedge clk) disable iff (!reset_n)
    (!fetchValid || !fetchWillExecute || fetchSeqCont) |=> iaHit == '0)
    else $error("instruction hit on a fetch that does not execute");
  a_ia_range_check: assert property (@(posedge clk) disable iff (!reset_n)
    iaHit[0] |-> $past(fetchCmpAddr) >= {32'h0, $past(iaStart[0])}
                 && $past(fetchCmpAddr) < {32'h0, $past(iaEnd[0])})
    else $error("instruction hit outside its range");
  a_oa_range_check: assert property (@(posedge clk) disable iff (!reset_n)
    oaHit[0] |-> $past(storeBlock) >= {32'h0, $past(oaStart[0]), 5'h00}
                 && $past(storeBlock) <= {32'h0, $past(oaEnd[0]), 5'h00})
    else $error("store hit outside its range");
  a_hole_no_hit: assert property (@(posedge clk) disable iff (!reset_n)
    writeAddressError |-> oaHit == '0 && $past(storeInHole))
    else $error("store in address hole produced a hit");
  a_vector_panic: assert property (@(posedge clk) disable iff (!reset_n)
    next_excReq ##1 debugExcReq |-> debugVectorOffset == ($past(blockBit) ? 12'h000 : 12'h100))
    else $error("wrong debug vector offset");
  a_ia_event_code: assert property (@(posedge clk) disable iff (!reset_n)
    (iaExc && !oaExc) |=> debugExcReq && exceptionEventCode == 12'h900)
    else $error("instruction exception code not loaded");
  a_saved_pc: assert property (@(posedge clk) disable iff (!reset_n)
    iaExc |=> savedProgramCounter == $past(fetchEffAddr))
    else $error("saved pc differs from matching fetch");
  a_hit_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    iaHit[0] |-> $past(fetchQualifies))
    else $error("hit without a qualifying fetch");
  a_range_reads: assert property (@(posedge clk) disable iff (!reset_n)
    regRead |=> regRdata[63:32] == 32'h0 || $past(regAddr[4:3]) == `ISAW_SUB_QUAL
               || $past(regAddr[11:8]) == `ISAW_STAT_BASE)
    else $error("range register upper half not zero");

  // ****************************************
  // store path and held outputs
  // ****************************************
  a_oa_hole_gate: assert property (
    storeInHole |=> oaHit == '0)
    else $error("hole store hit");

  a_hole_error: assert property (
    storeIsCand && storeInHole |=> writeAddressError)
    else $error("hole store without error");

  a_wae_cause: assert property (
    writeAddressError |-> $past(mmuEnable))
    else $error("hole error without translation");

  a_oa_kind_gate: assert property (
    !storeIsCand |=> oaHit == '0 && !writeAddressError)
    else $error("non-candidate store hit");

  a_oa_hit_cause: assert property (
    oaHit[0] |-> $past(storeQualifies))
    else $error("store hit without a store");

  a_exc_has_hit: assert property (
    debugExcReq |-> (|iaHit) || (|oaHit))
    else $error("exception without a hit");

  a_oa_event_code: assert property (
    oaExc |=> debugExcReq && exceptionEventCode == 12'h960)
    else $error("store exception code wrong");

  a_oa_addr_saved: assert property (
    oaExc |=> excOperandAddr == $past(storeEffAddr))
    else $error("store address not saved");

  a_pc_hold: assert property (
    !iaExc |=> $stable(savedProgramCounter))
    else $error("saved pc moved");

  a_vec_hold: assert property (
    !next_excReq |=> $stable(debugVectorOffset) && $stable(exceptionEventCode))
    else $error("vector or code moved");

  a_rdata_hold: assert property (
    !regRead |=> $stable(regRdata))
    else $error("read data moved");

endmodule // isaw_watchpoints

`default_nettype wire

// *** core/isaw_defs.svh ***
// register map, field positions and codes of the address watchpoint block
`ifndef ISAW_DEFS_SVH
`define ISAW_DEFS_SVH

// ****************************************
// register map (byte addresses, 64-bit words)
// ****************************************
`define ISAW_IA_BASE        4'h0
`define ISAW_OA_BASE        4'h1
`define ISAW_STAT_BASE      4'h2
`define ISAW_SUB_START      2'h0
`define ISAW_SUB_END        2'h1
`define ISAW_SUB_QUAL       2'h2
`define ISAW_ADDR_W         12

// ****************************************
// qualifier word fields
// ****************************************
`define ISAW_Q_ENABLE       0
`define ISAW_Q_ASID_EN      1
`define ISAW_Q_ISA_EN       2
`define ISAW_Q_ISA_VAL      3
`define ISAW_Q_PRIV_EN      4
`define ISAW_Q_PRIV_VAL     5
`define ISAW_Q_ECNT_EN      6
`define ISAW_Q_CHAIN_EN     7
`define ISAW_Q_ASID_LSB     8
`define ISAW_Q_ECNT_LSB     16
`define ISAW_Q_CHAIN_LSB    20
`define ISAW_Q_DM_ASID_EN   24
`define ISAW_Q_ACT_EXC      25
`define ISAW_QUAL_MASK      64'h0000_0000_03FF_FFFF
`define ISAW_QUAL_RESET     64'h0000_0000_0000_0000

// ****************************************
// exception codes and vector offsets
// ****************************************
`define ISAW_EXP_IA         12'h900
`define ISAW_EXP_OA         12'h960
`define ISAW_VEC_DEBUG      12'h100
`define ISAW_VEC_PANIC      12'h000
`define ISAW_BLOCK_SHIFT    5

`endif

// *** core/isaw_pkg.sv ***
// types shared by the address watchpoint block
`default_nettype none
package isaw_pkg;

  // class of memory-writing instruction presented by the pipeline
  typedef enum logic [3:0] {
    STORE_NONE,
    STORE_PLAIN,
    STORE_FLOAT,
    STORE_SWAP,
    STORE_LOW_PART,
    STORE_HIGH_PART,
    STORE_BLOCK_ALLOC,
    STORE_BLOCK_INVAL,
    STORE_COMPACT_IND,
    STORE_COMPACT_OTHER
  } isaw_store_kind_t;

endpackage

`default_nettype wire

// *** tb/isaw_cpu_model.sv ***
// pipeline model that presents fetch and store addresses to the watchpoints
`timescale 1ns/1ns
`default_nettype none

module isaw_cpu_model (
  // clock
  input  wire logic                      clk,
  // fetch side
  output logic                           fetchValid,
  output logic                           fetchWillExecute,
  output logic                           fetchSeqCont,
  output logic [63:0]                    fetchEffAddr,
  output logic [63:0]                    fetchPhysAddr,
  // store side
  output logic                           storeValid,
  output var isaw_pkg::isaw_store_kind_t storeKind,
  output logic [63:0]                    storeEffAddr,
  output logic [63:0]                    storePhysAddr
);
  // translation modelled as a flip of bit 16, so both views always differ
  localparam logic [63:0] XLATE = 64'h0000_0000_0001_0000;

  initial begin
    fetchValid       = 1'b0;
    fetchWillExecute = 1'b0;
    fetchSeqCont     = 1'b0;
    fetchEffAddr     = 64'h0;
    fetchPhysAddr    = 64'h0;
    storeValid       = 1'b0;
    storeKind        = isaw_pkg::STORE_NONE;
    storeEffAddr     = 64'h0;
    storePhysAddr    = 64'h0;
  end

  // one slot: driven after an edge, held up to the edge that takes it
  task automatic present(input logic fv, input logic ex, input logic sc, input logic [63:0] fa,
                         input logic sv, input isaw_pkg::isaw_store_kind_t k, input logic [63:0] sa);
    @(posedge clk);
    fetchValid       <= fv;
    fetchWillExecute <= ex;
    fetchSeqCont     <= sc;
    fetchEffAddr     <= fa;
    fetchPhysAddr    <= fa ^ XLATE;
    storeValid       <= sv;
    storeKind        <= k;
    storeEffAddr     <= sa;
    storePhysAddr    <= sa ^ XLATE;
    @(posedge clk);
    fetchValid       <= 1'b0;
    storeValid       <= 1'b0;
    // released address lines show the inverse so stale values cannot match
    fetchEffAddr     <= ~fa;
    fetchPhysAddr    <= ~(fa ^ XLATE);
    storeEffAddr     <= ~sa;
    storePhysAddr    <= ~(sa ^ XLATE);
  endtask
endmodule // isaw_cpu_model

`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the address watchpoint block
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic                       clk;
  logic                       reset_n;
  logic [11:0]                regAddr;
  logic [63:0]                regWdata;
  logic                       regWrite;
  logic                       regRead;
  logic [63:0]                regRdata;
  logic                       watch;
  logic                       block;
  logic                       mmu;
  logic [7:0]                 asid;
  logic                       priv;
  logic                       fetchValid;
  logic                       fetchWillExecute;
  logic                       fetchSeqCont;
  logic [63:0]                fetchEffAddr;
  logic [63:0]                fetchPhysAddr;
  logic                       storeValid;
  isaw_pkg::isaw_store_kind_t storeKind;
  isaw_pkg::isaw_store_kind_t kind;
  logic [63:0]                storeEffAddr;
  logic [63:0]                storePhysAddr;
  logic [1:0]                 iaHit;
  logic [1:0]                 oaHit;
  logic                       writeAddressError;
  logic                       debugExcReq;
  logic [11:0]                debugVectorOffset;
  logic [11:0]                exceptionEventCode;
  logic [63:0]                savedProgramCounter;
  logic [63:0]                excOperandAddr;
  logic                       hitExp;
  int                         fails;
  int                         compares;

  isaw_cpu_model u_cpu (.clk(clk), .fetchValid(fetchValid), .fetchWillExecute(fetchWillExecute),
    .fetchSeqCont(fetchSeqCont), .fetchEffAddr(fetchEffAddr), .fetchPhysAddr(fetchPhysAddr),
    .storeValid(storeValid), .storeKind(storeKind), .storeEffAddr(storeEffAddr),
    .storePhysAddr(storePhysAddr));

  // isa mode, counter and chain inputs are tied; space id and privilege are driven
  isaw_watchpoints #(.NUM_IA(2), .NUM_OA(2), .NEFF(32)) u_dut (.clk(clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .watchEnableFlag(watch), .blockBit(block), .mmuEnable(mmu),
    .curAsid(asid), .curIsaMode(1'b0), .curPriv(priv), .ecountReached(16'h0000),
    .chainArmed(16'h0000), .fetchValid(fetchValid), .fetchWillExecute(fetchWillExecute),
    .fetchSeqCont(fetchSeqCont), .fetchEffAddr(fetchEffAddr), .fetchPhysAddr(fetchPhysAddr),
    .storeValid(storeValid), .storeKind(storeKind), .storeEffAddr(storeEffAddr),
    .storePhysAddr(storePhysAddr), .iaHit(iaHit), .oaHit(oaHit),
    .writeAddressError(writeAddressError), .debugExcReq(debugExcReq),
    .debugVectorOffset(debugVectorOffset), .exceptionEventCode(exceptionEventCode),
    .savedProgramCounter(savedProgramCounter), .excOperandAddr(excOperandAddr));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // read data appear at the edge that ends the strobe and hold until the next read
  task automatic rd(input logic [11:0] a, input logic [63:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    check(regRdata, exp);
  endtask

  task automatic outs(input logic [1:0] ia, input logic [1:0] oa, input logic wae, input logic exc);
    check({58'h0, iaHit, oaHit, writeAddressError, debugExcReq}, {58'h0, ia, oa, wae, exc});
  endtask

  task automatic fetch(input logic [63:0] a, input logic ex, input logic sc,
                       input logic [1:0] ia, input logic exc);
    u_cpu.present(1'b1, ex, sc, a, 1'b0, isaw_pkg::STORE_NONE, 64'h0);
    #1;
    outs(ia, 2'b00, 1'b0, exc);
  endtask

  task automatic store(input isaw_pkg::isaw_store_kind_t k, input logic [63:0] a,
                       input logic [1:0] oa, input logic wae, input logic exc);
    u_cpu.present(1'b0, 1'b0, 1'b0, 64'h0, 1'b1, k, a);
    #1;
    outs(2'b00, oa, wae, exc);
  endtask

  initial begin
    #400000;
    fails++;
    report_and_stop();
  end

  initial begin
    reset_n  = 1'b0;
    regAddr  = 12'h000;
    regWdata = 64'h0;
    regWrite = 1'b0;
    regRead  = 1'b0;
    watch    = 1'b1;
    block    = 1'b0;
    mmu      = 1'b1;
    asid     = 8'h00;
    priv     = 1'b0;
    fails    = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    wr(12'h000, 64'hFFFF_FFFF_FFFF_FFFE);
    rd(12'h000, 64'h0000_0000_FFFF_FFFE);
    wr(12'h128, 64'hFFFF_FFFF_FFFF_FFFF);
    rd(12'h128, 64'h0000_0000_FFFF_FFE0);
    rd(12'h004, 64'h0);
    rd(12'h300, 64'h0);
    $display("test registers done");
    // ranges are written while the channels are still disabled
    wr(12'h000, 64'h1000);
    wr(12'h008, 64'h2000);
    wr(12'h020, 64'h1FFE);
    wr(12'h028, 64'h3000);
    wr(12'h010, 64'h0200_0001);
    wr(12'h030, 64'h0000_0001);
    fetch(64'h0FFE, 1'b1, 1'b0, 2'b00, 1'b0);
    fetch(64'h1000, 1'b1, 1'b0, 2'b01, 1'b1);
    check(savedProgramCounter, 64'h1000);
    check({52'h0, exceptionEventCode}, 64'h900);
    check({52'h0, debugVectorOffset}, 64'h100);
    @(posedge clk);
    #1;
    outs(2'b00, 2'b00, 1'b0, 1'b0);
    fetch(64'h1FFE, 1'b1, 1'b0, 2'b11, 1'b1);
    fetch(64'h2000, 1'b1, 1'b0, 2'b10, 1'b0);
    fetch(64'h1000, 1'b0, 1'b0, 2'b00, 1'b0);
    fetch(64'h1000, 1'b1, 1'b1, 2'b00, 1'b0);
    fetch(64'hFFFF_FFFF_0000_1000, 1'b1, 1'b0, 2'b00, 1'b0);
    @(posedge clk);
    block <= 1'b1;
    fetch(64'h1004, 1'b1, 1'b0, 2'b01, 1'b1);
    check({52'h0, debugVectorOffset}, 64'h000);
    @(posedge clk);
    block <= 1'b0;
    mmu   <= 1'b0;
    fetch(64'h0001_1000, 1'b1, 1'b0, 2'b01, 1'b1);
    fetch(64'h1000, 1'b1, 1'b0, 2'b00, 1'b0);
    @(posedge clk);
    mmu <= 1'b1;
    // clear the enable first, then requalify
    wr(12'h030, 64'h0);
    wr(12'h030, 64'h5A13);
    fetch(64'h2000, 1'b1, 1'b0, 2'b00, 1'b0);
    @(posedge clk);
    asid <= 8'h5A;
    fetch(64'h2000, 1'b1, 1'b0, 2'b10, 1'b0);
    @(posedge clk);
    priv <= 1'b1;
    fetch(64'h2000, 1'b1, 1'b0, 2'b00, 1'b0);
    $display("test instruction channels done");
    wr(12'h100, 64'h4000);
    wr(12'h108, 64'h4020);
    wr(12'h110, 64'h0200_0001);
    for (int k = 0; k < 10; k++) begin
      kind   = isaw_pkg::isaw_store_kind_t'(4'(k));
      hitExp = (kind != isaw_pkg::STORE_NONE) && (kind != isaw_pkg::STORE_COMPACT_OTHER);
      store(kind, 64'h403F, {1'b0, hitExp}, 1'b0, hitExp);
    end
    store(isaw_pkg::STORE_PLAIN, 64'h4005, 2'b01, 1'b0, 1'b1);
    check(excOperandAddr, 64'h4005);
    check({52'h0, exceptionEventCode}, 64'h960);
    store(isaw_pkg::STORE_PLAIN, 64'h3FFF, 2'b00, 1'b0, 1'b0);
    store(isaw_pkg::STORE_PLAIN, 64'h4040, 2'b00, 1'b0, 1'b0);
    store(isaw_pkg::STORE_SWAP, 64'h0000_0001_0000_4000, 2'b00, 1'b1, 1'b0);
    @(posedge clk);
    watch <= 1'b0;
    fetch(64'h1000, 1'b1, 1'b0, 2'b00, 1'b0);
    store(isaw_pkg::STORE_PLAIN, 64'h4000, 2'b00, 1'b0, 1'b0);
    rd(12'h200, 64'h0000_0000_0000_0100);
    $display("test store channels done");
    report_and_stop();
  end
endmodule // tb_top

`default_nettype wire
